// ===== logic/rcm_pkg.sv
// Shared constants for the rate converter mute and lock control block
package rcm_pkg;
	// Register indices; byte address is four times the index
	localparam logic [17:0] IDX_LOCK_MUTE_LO = 18'h0e101;
	localparam logic [17:0] IDX_RAMP_DIS_LO = 18'h0e103;
	localparam logic [17:0] IDX_LOCK_MUTE_HI = 18'h0e141;
	localparam logic [17:0] IDX_RAMP_DIS_HI = 18'h0e143;
	localparam logic [17:0] IDX_IRQ_STATUS = 18'h0e180;
	localparam logic [17:0] IDX_IRQ_CLEAR = 18'h0e181;
	localparam logic [17:0] IDX_IRQ_ENABLE = 18'h0e182;
	// Field positions inside the 16-bit registers
	localparam int MUTE_LSB = 0;
	localparam int LOCK_LSB = 8;
	localparam int RDIS_BIT = 0;
	localparam int GRP_N = 4;
	// Reset values
	localparam logic [7:0] MUTE_RST = 8'h00;
	localparam logic [1:0] RDIS_RST = 2'h0;
	localparam logic [7:0] LOCK_RST = 8'h00;
	localparam logic [15:0] IRQ_RST = 16'h0000;
	// Gain scale: unity gain and its fraction bits
	localparam logic [8:0] GAIN_UNITY = 9'h080;
	localparam int GAIN_FRAC = 7;
	localparam int RATE_W = 6;
	// Timing
	localparam int CLK_NS = 20;
	localparam int LOCK_HOLD_NS = 1000;
	localparam int RAMP_STEP_NS = 160;
	localparam int LOCK_HOLD_CYC = (LOCK_HOLD_NS + CLK_NS - 1) / CLK_NS;
	localparam int RAMP_STEP_CYC = (RAMP_STEP_NS + CLK_NS - 1) / CLK_NS;
endpackage

// ===== logic/rcm_ramp_if.sv
// Link between the control logic and one converter's gain ramp
`timescale 1ns/1ps
`default_nettype none
interface rcm_ramp_if #(parameter int SW = 24);
	logic mute_req;
	logic abrupt;
	logic step;
	logic [8:0] gain;
	logic muted;
	logic signed [SW-1:0] in_l;
	logic signed [SW-1:0] in_r;
	logic in_valid;
	logic signed [SW-1:0] out_l;
	logic signed [SW-1:0] out_r;
	logic out_valid;
	modport ctrl (output mute_req, abrupt, step, in_l, in_r, in_valid,
		input gain, muted, out_l, out_r, out_valid);
	modport ramp (input mute_req, abrupt, step, in_l, in_r, in_valid,
		output gain, muted, out_l, out_r, out_valid);
endinterface
`default_nettype wire

// ===== logic/rcm_gain_ramp.sv
// Per-converter gain ramp and stereo sample scaling
`timescale 1ns/1ps
`default_nettype none
module rcm_gain_ramp #(parameter int SW = 24) (
	input wire logic clk,
	input wire logic sys_rst,
	rcm_ramp_if.ramp bus
);
	typedef struct packed {
		logic [8:0] gain;
		logic signed [SW-1:0] l;
		logic signed [SW-1:0] r;
		logic vld;
	} rcm_ramp_st_t;
	rcm_ramp_st_t st_q;
	rcm_ramp_st_t st_d;
	logic signed [SW+9:0] prod_l;
	logic signed [SW+9:0] prod_r;

	// Scale samples by the current gain
	assign prod_l = bus.in_l * $signed({1'b0, st_q.gain});
	assign prod_r = bus.in_r * $signed({1'b0, st_q.gain});

	// Ramp gain toward target, or jump when abrupt
	always_comb begin
		st_d = st_q;
		if (bus.mute_req) begin
			if (bus.abrupt) begin
				st_d.gain = 9'h000;
			end else if (bus.step && st_q.gain != 9'h000) begin
				st_d.gain = st_q.gain - 9'h001;
			end
		end else begin
			if (bus.abrupt) begin
				st_d.gain = rcm_pkg::GAIN_UNITY;
			end else if (bus.step && st_q.gain < rcm_pkg::GAIN_UNITY) begin
				st_d.gain = st_q.gain + 9'h001;
			end
		end
		st_d.vld = bus.in_valid;
		if (bus.in_valid) begin
			st_d.l = prod_l[SW+rcm_pkg::GAIN_FRAC-1:rcm_pkg::GAIN_FRAC];
			st_d.r = prod_r[SW+rcm_pkg::GAIN_FRAC-1:rcm_pkg::GAIN_FRAC];
		end
	end

	// State register; starts muted
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign bus.gain = st_q.gain;
	assign bus.muted = (st_q.gain == 9'h000);
	assign bus.out_l = st_q.l;
	assign bus.out_r = st_q.r;
	assign bus.out_valid = st_q.vld;

	property p_abrupt_mute;
		@(posedge clk) disable iff (sys_rst)
		bus.mute_req && bus.abrupt |=> st_q.gain == 9'h000;
	endproperty
	a_abrupt_mute: assert property (p_abrupt_mute) else $error("abrupt mute not immediate");

	property p_ramp_down;
		@(posedge clk) disable iff (sys_rst)
		bus.mute_req && !bus.abrupt && bus.step && st_q.gain != 9'h000
			|=> st_q.gain == $past(st_q.gain) - 9'h001;
	endproperty
	a_ramp_down: assert property (p_ramp_down) else $error("ramp step missing");
endmodule
`default_nettype wire

// ===== logic/rcm_ctrl.sv
// Mute and lock control for eight stereo rate converters behind Wishbone
// Notes on behaviour
// - Mute bits active high, bits 3..0
// - Ratio lost clears lock bit and mutes
// - Muting ramps volume by default
// - Low group ramp-disable bit makes mute abrupt
// - High group ramp-disable bit makes mute abrupt
// - Ramp-disable set ignores that group's manual mutes
// - Low register: lock bits 11..8, mute 3..0
// - High register: lock bits 11..8, mute 3..0
// - Converter n carries channels 2n, 2n+1
// - Registers 16 bits, fields reset to 0
// - Audio moves only through the routing matrix
// - No-converter variant ignores these register writes
// - Eight converters in two groups of four
// - Shared-rate variant copies converter 0/4 rate
`timescale 1ns/1ps
`default_nettype none
module rcm_ctrl #(
	parameter int NCONV = 8,
	parameter int SAMPLE_W = 24,
	parameter int HAS_CONVERTERS = 1,
	parameter int GROUP_RATE = 0,
	parameter int LOCK_CYCLES = rcm_pkg::LOCK_HOLD_CYC,
	parameter int RAMP_DIV = rcm_pkg::RAMP_STEP_CYC
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [19:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic irq,
	input wire logic [NCONV-1:0] ratio_ok,
	input wire logic [NCONV*2*SAMPLE_W-1:0] rm_in_data,
	input wire logic [NCONV-1:0] rm_in_valid,
	output logic [NCONV*2*SAMPLE_W-1:0] rm_out_data,
	output logic [NCONV-1:0] rm_out_valid,
	output logic [NCONV-1:0] conv_muted,
	input wire logic [NCONV*rcm_pkg::RATE_W-1:0] rate_sel_in,
	output logic [NCONV*rcm_pkg::RATE_W-1:0] rate_sel_out
);
	localparam int NGRP = NCONV / rcm_pkg::GRP_N;

	typedef struct packed {
		logic ack;
		logic [31:0] rdat;
		logic [7:0] mute;
		logic [1:0] rdis;
		logic [7:0] locked;
		logic [7:0][15:0] lcnt;
		logic [15:0] ist;
		logic [15:0] ien;
		logic [15:0] tick;
	} rcm_ctrl_st_t;
	rcm_ctrl_st_t st_q;
	rcm_ctrl_st_t st_d;

	logic [17:0] adr_idx;
	logic req;
	logic wr;
	logic wr_lo;
	logic wr_hi;
	logic hit_lm_lo;
	logic hit_rd_lo;
	logic hit_lm_hi;
	logic hit_rd_hi;
	logic hit_ist;
	logic hit_iclr;
	logic hit_ien;
	logic [31:0] rd_val;
	logic [15:0] ev_set;
	logic [15:0] ev_clr;
	logic step;
	logic [7:0] mute_req;
	logic conv_en;

	rcm_ramp_if #(.SW(SAMPLE_W)) rif[NCONV] ();

	// Bus decode; registers sit on word indices
	assign adr_idx = wb_adr_i[19:2];
	assign req = wb_cyc_i & wb_stb_i & ~st_q.ack;
	assign wr = req & wb_we_i;
	assign wr_lo = wr & wb_sel_i[0];
	assign wr_hi = wr & wb_sel_i[1];
	assign hit_lm_lo = (adr_idx == rcm_pkg::IDX_LOCK_MUTE_LO);
	assign hit_rd_lo = (adr_idx == rcm_pkg::IDX_RAMP_DIS_LO);
	assign hit_lm_hi = (adr_idx == rcm_pkg::IDX_LOCK_MUTE_HI);
	assign hit_rd_hi = (adr_idx == rcm_pkg::IDX_RAMP_DIS_HI);
	assign hit_ist = (adr_idx == rcm_pkg::IDX_IRQ_STATUS);
	assign hit_iclr = (adr_idx == rcm_pkg::IDX_IRQ_CLEAR);
	assign hit_ien = (adr_idx == rcm_pkg::IDX_IRQ_ENABLE);
	assign conv_en = (HAS_CONVERTERS != 0);

	// Shared ramp tick
	assign step = (st_q.tick == 16'(RAMP_DIV - 1));

	// Read data mux; reserved bits and unmapped addresses read zero
	always_comb begin
		rd_val = 32'h00000000;
		if (hit_lm_lo) begin
			rd_val[rcm_pkg::LOCK_LSB +: 4] = st_q.locked[3:0];
			rd_val[rcm_pkg::MUTE_LSB +: 4] = st_q.mute[3:0];
		end else if (hit_lm_hi) begin
			rd_val[rcm_pkg::LOCK_LSB +: 4] = st_q.locked[7:4];
			rd_val[rcm_pkg::MUTE_LSB +: 4] = st_q.mute[7:4];
		end else if (hit_rd_lo) begin
			rd_val[rcm_pkg::RDIS_BIT] = st_q.rdis[0];
		end else if (hit_rd_hi) begin
			rd_val[rcm_pkg::RDIS_BIT] = st_q.rdis[1];
		end else if (hit_ist) begin
			rd_val[15:0] = st_q.ist;
		end else if (hit_ien) begin
			rd_val[15:0] = st_q.ien;
		end
	end

	// Clear mask from the write-only clear register
	always_comb begin
		ev_clr = 16'h0000;
		if (hit_iclr && wr_lo) begin
			ev_clr[7:0] = wb_dat_i[7:0];
		end
		if (hit_iclr && wr_hi) begin
			ev_clr[15:8] = wb_dat_i[15:8];
		end
	end

	// Next-state logic: bus, lock detection, events, tick
	always_comb begin
		st_d = st_q;
		ev_set = 16'h0000;
		st_d.ack = req;
		if (req) begin
			st_d.rdat = rd_val;
		end
		// Register writes; converter controls only exist in the full variant
		if (conv_en && wr_lo) begin
			if (hit_lm_lo) begin
				st_d.mute[3:0] = wb_dat_i[rcm_pkg::MUTE_LSB +: 4];
			end
			if (hit_lm_hi) begin
				st_d.mute[7:4] = wb_dat_i[rcm_pkg::MUTE_LSB +: 4];
			end
			if (hit_rd_lo) begin
				st_d.rdis[0] = wb_dat_i[rcm_pkg::RDIS_BIT];
			end
			if (hit_rd_hi) begin
				st_d.rdis[1] = wb_dat_i[rcm_pkg::RDIS_BIT];
			end
		end
		if (hit_ien && wr_lo) begin
			st_d.ien[7:0] = wb_dat_i[7:0];
		end
		if (hit_ien && wr_hi) begin
			st_d.ien[15:8] = wb_dat_i[15:8];
		end
		// Lock: held ratio for LOCK_CYCLES sets it, any loss clears it
		for (int k = 0; k < NCONV; k++) begin
			if (!ratio_ok[k] || !conv_en) begin
				st_d.lcnt[k] = 16'h0000;
				st_d.locked[k] = 1'b0;
				ev_set[k] = st_q.locked[k];
			end else if (!st_q.locked[k]) begin
				if (st_q.lcnt[k] == 16'(LOCK_CYCLES - 1)) begin
					st_d.locked[k] = 1'b1;
					ev_set[8+k] = 1'b1;
				end else begin
					st_d.lcnt[k] = st_q.lcnt[k] + 16'h0001;
				end
			end
		end
		// Sticky events; a set in the clearing cycle wins
		st_d.ist = (st_q.ist & ~ev_clr) | ev_set;
		st_d.tick = step ? 16'h0000 : st_q.tick + 16'h0001;
	end

	// State register
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			st_q.ack <= 1'b0;
			st_q.rdat <= 32'h00000000;
			st_q.mute <= rcm_pkg::MUTE_RST;
			st_q.rdis <= rcm_pkg::RDIS_RST;
			st_q.locked <= rcm_pkg::LOCK_RST;
			st_q.lcnt <= '0;
			st_q.ist <= rcm_pkg::IRQ_RST;
			st_q.ien <= rcm_pkg::IRQ_RST;
			st_q.tick <= 16'h0000;
		end else begin
			st_q <= st_d;
		end
	end

	assign wb_ack_o = st_q.ack;
	assign wb_dat_o = st_q.rdat;
	assign irq = |(st_q.ist & st_q.ien);

	// Converters: two groups of four, each converter with its own ramp
	generate
		for (genvar k = 0; k < NCONV; k++) begin : g_conv
			localparam int G = k / rcm_pkg::GRP_N;
			// Auto mute on lost lock; manual mute only while ramping is enabled
			assign mute_req[k] = ~st_q.locked[k] | (st_q.mute[k] & ~st_q.rdis[G]);
			assign rif[k].mute_req = mute_req[k];
			assign rif[k].abrupt = st_q.rdis[G];
			assign rif[k].step = step;
			// Channels 2k and 2k+1 come from and return to the routing matrix
			assign rif[k].in_l = rm_in_data[(2*k)*SAMPLE_W +: SAMPLE_W];
			assign rif[k].in_r = rm_in_data[(2*k+1)*SAMPLE_W +: SAMPLE_W];
			assign rif[k].in_valid = rm_in_valid[k];
			assign rm_out_data[(2*k)*SAMPLE_W +: SAMPLE_W] = rif[k].out_l;
			assign rm_out_data[(2*k+1)*SAMPLE_W +: SAMPLE_W] = rif[k].out_r;
			assign rm_out_valid[k] = rif[k].out_valid;
			assign conv_muted[k] = rif[k].muted;
			// Output rate follows the group leader in the shared-rate variant
			if (GROUP_RATE != 0) begin : g_shared
				assign rate_sel_out[k*rcm_pkg::RATE_W +: rcm_pkg::RATE_W] =
					rate_sel_in[G*rcm_pkg::GRP_N*rcm_pkg::RATE_W +: rcm_pkg::RATE_W];
			end else begin : g_own
				assign rate_sel_out[k*rcm_pkg::RATE_W +: rcm_pkg::RATE_W] =
					rate_sel_in[k*rcm_pkg::RATE_W +: rcm_pkg::RATE_W];
			end
			rcm_gain_ramp #(.SW(SAMPLE_W)) u_ramp (
				.clk(clk),
				.sys_rst(sys_rst),
				.bus(rif[k])
			);
		end
	endgenerate

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);

	// Accepted write to the low lock/mute register with mute bit 0 set
	sequence s_wr_mute0;
		wr_lo && hit_lm_lo && wb_dat_i[0] && conv_en;
	endsequence
	sequence s_read_lo;
		req && !wb_we_i && hit_lm_lo;
	endsequence
	sequence s_read_hi;
		req && !wb_we_i && hit_lm_hi;
	endsequence

	property p_manual_mute;
		s_wr_mute0 ##1 (st_q.locked[0] && !st_q.rdis[0]) |-> mute_req[0];
	endproperty
	a_manual_mute: assert property (p_manual_mute) else $error("manual mute not applied");

	property p_lock_loss;
		!ratio_ok[0] |=> !st_q.locked[0] && mute_req[0];
	endproperty
	a_lock_loss: assert property (p_lock_loss) else $error("lock loss did not mute");

	property p_ignore_manual;
		st_q.rdis[1] && st_q.locked[4] |-> !mute_req[4];
	endproperty
	a_ignore_manual: assert property (p_ignore_manual) else $error("manual mute not ignored");

	property p_abrupt_hi;
		st_q.rdis[1] && !st_q.locked[5] |=> conv_muted[5];
	endproperty
	a_abrupt_hi: assert property (p_abrupt_hi) else $error("abrupt select wrong");

	property p_read_lo;
		s_read_lo |=> wb_ack_o && wb_dat_o[11:8] == $past(st_q.locked[3:0]);
	endproperty
	a_read_lo: assert property (p_read_lo) else $error("low lock read wrong");

	property p_read_hi;
		s_read_hi |=> wb_ack_o && wb_dat_o[11:8] == $past(st_q.locked[7:4])
			&& wb_dat_o[3:0] == $past(st_q.mute[7:4]);
	endproperty
	a_read_hi: assert property (p_read_hi) else $error("high lock read wrong");

	property p_width;
		wb_ack_o |-> wb_dat_o[31:16] == 16'h0000 ##1 !wb_ack_o;
	endproperty
	a_width: assert property (p_width) else $error("upper bits or ack wrong");

	property p_no_conv;
		!conv_en |-> st_q.mute == 8'h00 && st_q.rdis == 2'h0;
	endproperty
	a_no_conv: assert property (p_no_conv) else $error("write took effect");

	property p_shared_rate;
		GROUP_RATE != 0 |-> rate_sel_out[2*rcm_pkg::RATE_W +: rcm_pkg::RATE_W]
			== rate_sel_in[0 +: rcm_pkg::RATE_W];
	endproperty
	a_shared_rate: assert property (p_shared_rate) else $error("group rate not shared");

	property p_regain;
		$rose(st_q.locked[0]) |-> st_q.ist[8] && $past(st_q.lcnt[0]) == 16'(LOCK_CYCLES - 1);
	endproperty
	a_regain: assert property (p_regain) else $error("regain event wrong");

	// Further checks on writes, events, the output strobe and abrupt recovery
	property p_unmute_abrupt;
		st_q.rdis[0] && st_q.locked[1] |=> !conv_muted[1];
	endproperty
	a_unmute_abrupt: assert property (p_unmute_abrupt) else $error("abrupt unmute missing");

	property p_rdis_write;
		wr_lo && hit_rd_lo && conv_en |=> st_q.rdis[0] == $past(wb_dat_i[0]);
	endproperty
	a_rdis_write: assert property (p_rdis_write) else $error("low ramp disable lost");

	property p_rdis_apart;
		wr_lo && hit_rd_lo |=> st_q.rdis[1] == $past(st_q.rdis[1]);
	endproperty
	a_rdis_apart: assert property (p_rdis_apart) else $error("high ramp disable disturbed");

	property p_mute_hi_write;
		wr_lo && hit_lm_hi && conv_en |=> st_q.mute[7:4] == $past(wb_dat_i[3:0]);
	endproperty
	a_mute_hi_write: assert property (p_mute_hi_write) else $error("high mute write lost");

	property p_lost_event;
		st_q.locked[1] && !ratio_ok[1] |=> st_q.ist[1];
	endproperty
	a_lost_event: assert property (p_lost_event) else $error("lock loss event missing");

	property p_out_follows;
		rm_in_valid[3] |=> rm_out_valid[3];
	endproperty
	a_out_follows: assert property (p_out_follows) else $error("output strobe missing");

	property p_sticky;
		st_q.ist[13] && !ev_clr[13] |=> st_q.ist[13];
	endproperty
	a_sticky: assert property (p_sticky) else $error("status bit not sticky");
endmodule
`default_nettype wire

// ===== bench/rcm_rm_model.sv
// Routing matrix model that feeds stereo samples to the eight converters
`timescale 1ns/1ps
`default_nettype none
module rcm_rm_model (
	input wire logic clk,
	input wire logic sys_rst,
	output logic [383:0] rm_in_data,
	output logic [7:0] rm_in_valid
);
	logic [1:0] cnt_q;
	logic [383:0] pat;
	// Fixed sample per channel: upper byte 0x10 plus channel number
	always_comb begin
		for (int c = 0; c < 16; c++) begin
			pat[c*24 +: 24] = {8'h10 + 8'(c), 16'h0000};
		end
	end
	// Strobe all converters every fourth cycle; lines carry the inverse between strobes
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			cnt_q <= 2'h0;
			rm_in_valid <= 8'h00;
			rm_in_data <= 384'h0;
		end else begin
			cnt_q <= cnt_q + 2'h1;
			rm_in_valid <= (cnt_q == 2'h0) ? 8'hff : 8'h00;
			rm_in_data <= (cnt_q == 2'h0) ? pat : ~pat;
		end
	end
endmodule
`default_nettype wire

// ===== bench/rate_converter_mute_lock_ctrl_tb.sv
// Self-checking bench for the rate converter mute and lock control
`timescale 1ns/1ps
`default_nettype none
module rate_converter_mute_lock_ctrl_tb;
	localparam int LCK = 4;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [19:0] adr = 20'h00000;
	logic [31:0] dat = 32'h00000000;
	logic [31:0] dat_o;
	logic ack;
	logic irq;
	logic [7:0] ratio_ok = 8'h00;
	logic [383:0] rm_in_data;
	logic [7:0] rm_in_valid;
	logic [383:0] rm_out_data;
	logic [7:0] rm_out_valid;
	logic [7:0] conv_muted;
	logic [47:0] rate_out;
	logic [47:0] rate_in = 48'h000000000000;
	logic [31:0] dat_lite;
	logic [31:0] dat_lite_q = 32'h00000000;
	logic ack_lite;
	logic [7:0] muted_lite;
	logic [47:0] rate_lite;
	int n_mismatch = 0;
	int total_checks = 0;
	int cycles = 0;
	// Clock and hang guard
	always #10 clk = ~clk;
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			n_mismatch = n_mismatch + 1;
			complete_run();
		end
	end
	rcm_ctrl #(.LOCK_CYCLES(LCK), .RAMP_DIV(2)) u_rcm_ctrl (
		.clk(clk), .sys_rst(sys_rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(4'h3), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
		.irq(irq), .ratio_ok(ratio_ok), .rm_in_data(rm_in_data), .rm_in_valid(rm_in_valid),
		.rm_out_data(rm_out_data), .rm_out_valid(rm_out_valid), .conv_muted(conv_muted),
		.rate_sel_in(rate_in), .rate_sel_out(rate_out));
	// Variant without converters and with shared group rates, on the same bus
	rcm_ctrl #(.LOCK_CYCLES(LCK), .RAMP_DIV(2), .HAS_CONVERTERS(0), .GROUP_RATE(1))
		u_rcm_ctrl_lite (
		.clk(clk), .sys_rst(sys_rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(4'h3), .wb_dat_i(dat), .wb_dat_o(dat_lite),
		.wb_ack_o(ack_lite), .irq(), .ratio_ok(ratio_ok), .rm_in_data(rm_in_data),
		.rm_in_valid(rm_in_valid), .rm_out_data(), .rm_out_valid(), .conv_muted(muted_lite),
		.rate_sel_in(rate_in), .rate_sel_out(rate_lite));
	rcm_rm_model u_rcm_rm_model (.clk(clk), .sys_rst(sys_rst), .rm_in_data(rm_in_data),
		.rm_in_valid(rm_in_valid));
	task automatic chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
		total_checks = total_checks + 1;
		if (g !== e) begin
			n_mismatch = n_mismatch + 1;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic chk_bits(input string nm, input logic [7:0] e, input logic [7:0] g);
		chk_word(nm, {24'h0, e}, {24'h0, g});
	endtask
	// One classic Wishbone cycle; ack and read data sampled where settled
	task automatic wb(input logic w, input logic [17:0] idx, input logic [15:0] d,
		output logic [31:0] q);
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= {idx, 2'b00};
		dat <= {16'h0000, d};
		// Request stands until ack is seen at a rising edge; only the hang guard ends this
		do begin
			@(posedge clk);
		end while (ack !== 1'b1);
		q = dat_o;
		dat_lite_q = dat_lite;
		chk_bits("ack_lite", 8'h01, {7'h0, ack_lite});
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask
	task automatic wr(input logic [17:0] idx, input logic [15:0] d);
		logic [31:0] q;
		wb(1'b1, idx, d, q);
	endtask
	task automatic rd(input logic [17:0] idx, input logic [15:0] e);
		logic [31:0] q;
		wb(1'b0, idx, 16'h0000, q);
		chk_word("register", {16'h0000, e}, q);
	endtask
	task automatic wait_muted(input logic [7:0] e, output int n);
		n = 0;
		while (conv_muted !== e && n < 600) begin
			@(negedge clk);
			n = n + 1;
		end
		chk_bits("conv_muted", e, conv_muted);
	endtask
	task automatic wait_out(input int c);
		int k;
		k = 0;
		do begin
			@(negedge clk);
			k = k + 1;
		end while (rm_out_valid[c] !== 1'b1 && k < 20);
		chk_bits("out_valid", 8'h01, {7'h0, rm_out_valid[c]});
	endtask
	task automatic t_reset;
		rd(rcm_pkg::IDX_LOCK_MUTE_LO, 16'h0000);
		rd(rcm_pkg::IDX_LOCK_MUTE_HI, 16'h0000);
		rd(rcm_pkg::IDX_RAMP_DIS_LO, 16'h0000);
		rd(rcm_pkg::IDX_RAMP_DIS_HI, 16'h0000);
		chk_bits("conv_muted", 8'hff, conv_muted);
		wait_out(0);
		chk_word("ch0", 32'h0, {8'h0, rm_out_data[23:0]});
		$display("test reset done");
	endtask
	task automatic t_lock;
		int n;
		@(posedge clk);
		ratio_ok <= 8'hff;
		repeat (LCK + 2) @(posedge clk);
		rd(rcm_pkg::IDX_LOCK_MUTE_LO, 16'h0f00);
		rd(rcm_pkg::IDX_LOCK_MUTE_HI, 16'h0f00);
		rd(rcm_pkg::IDX_IRQ_STATUS, 16'hff00);
		wr(rcm_pkg::IDX_IRQ_CLEAR, 16'hffff);
		rd(rcm_pkg::IDX_IRQ_STATUS, 16'h0000);
		rd(rcm_pkg::IDX_IRQ_CLEAR, 16'h0000);
		wait_muted(8'h00, n);
		// Let the gain ramp reach unity before judging the samples
		repeat (300) @(posedge clk);
		wait_out(7);
		chk_word("ch14", {8'h0, 8'h1e, 16'h0}, {8'h0, rm_out_data[14*24 +: 24]});
		chk_word("ch15", {8'h0, 8'h1f, 16'h0}, {8'h0, rm_out_data[15*24 +: 24]});
		$display("test lock done");
	endtask
	task automatic t_ramp;
		int n;
		wr(rcm_pkg::IDX_LOCK_MUTE_LO, 16'hff05);
		wr(rcm_pkg::IDX_LOCK_MUTE_HI, 16'h0008);
		rd(rcm_pkg::IDX_LOCK_MUTE_LO, 16'h0f05);
		chk_bits("conv_muted", 8'h00, conv_muted);
		wait_muted(8'h85, n);
		chk_bits("ramp_long", 8'h01, {7'h0, n > 150});
		wr(rcm_pkg::IDX_LOCK_MUTE_LO, 16'h0000);
		wr(rcm_pkg::IDX_LOCK_MUTE_HI, 16'h0000);
		wait_muted(8'h00, n);
		$display("test ramp done");
	endtask
	task automatic t_rdis;
		int n;
		wr(rcm_pkg::IDX_RAMP_DIS_LO, 16'h0001);
		wr(rcm_pkg::IDX_RAMP_DIS_HI, 16'h0001);
		rd(rcm_pkg::IDX_RAMP_DIS_LO, 16'h0001);
		rd(rcm_pkg::IDX_RAMP_DIS_HI, 16'h0001);
		wr(rcm_pkg::IDX_LOCK_MUTE_LO, 16'h000f);
		wr(rcm_pkg::IDX_LOCK_MUTE_HI, 16'h000f);
		repeat (4) @(posedge clk);
		chk_bits("conv_muted", 8'h00, conv_muted);
		wr(rcm_pkg::IDX_IRQ_ENABLE, 16'h0022);
		rd(rcm_pkg::IDX_IRQ_ENABLE, 16'h0022);
		@(posedge clk);
		ratio_ok <= 8'hdd;
		repeat (3) @(posedge clk);
		@(negedge clk);
		chk_bits("conv_muted", 8'h22, conv_muted);
		chk_bits("irq", 8'h01, {7'h0, irq});
		rd(rcm_pkg::IDX_LOCK_MUTE_LO, 16'h0d0f);
		rd(rcm_pkg::IDX_LOCK_MUTE_HI, 16'h0d0f);
		@(posedge clk);
		ratio_ok <= 8'hff;
		repeat (LCK + 2) @(posedge clk);
		wr(rcm_pkg::IDX_IRQ_CLEAR, 16'hffff);
		@(negedge clk);
		chk_bits("irq", 8'h00, {7'h0, irq});
		chk_bits("conv_muted", 8'h00, conv_muted);
		wr(rcm_pkg::IDX_LOCK_MUTE_LO, 16'h0000);
		wr(rcm_pkg::IDX_LOCK_MUTE_HI, 16'h0000);
		wr(rcm_pkg::IDX_RAMP_DIS_LO, 16'h0000);
		wr(rcm_pkg::IDX_RAMP_DIS_HI, 16'h0000);
		$display("test ramp disable done");
	endtask
	task automatic t_variant;
		@(posedge clk);
		rate_in <= {6'h08, 6'h07, 6'h06, 6'h05, 6'h04, 6'h03, 6'h02, 6'h01};
		@(negedge clk);
		chk_word("rate", {8'h0, 6'h04, 6'h03, 6'h02, 6'h01}, {8'h0, rate_out[23:0]});
		chk_word("rate", {8'h0, 6'h08, 6'h07, 6'h06, 6'h05}, {8'h0, rate_out[47:24]});
		chk_word("rate_sh", {8'h0, {4{6'h01}}}, {8'h0, rate_lite[23:0]});
		chk_word("rate_sh", {8'h0, {4{6'h05}}}, {8'h0, rate_lite[47:24]});
		wr(rcm_pkg::IDX_LOCK_MUTE_LO, 16'h000f);
		wr(rcm_pkg::IDX_RAMP_DIS_HI, 16'h0001);
		rd(rcm_pkg::IDX_LOCK_MUTE_LO, 16'h0f0f);
		chk_word("lite_lock_mute", 32'h00000000, dat_lite_q);
		rd(rcm_pkg::IDX_RAMP_DIS_HI, 16'h0001);
		chk_word("lite_ramp_dis", 32'h00000000, dat_lite_q);
		chk_bits("lite_muted", 8'hff, muted_lite);
		wr(rcm_pkg::IDX_LOCK_MUTE_LO, 16'h0000);
		wr(rcm_pkg::IDX_RAMP_DIS_HI, 16'h0000);
		$display("test variants done");
	endtask
	task automatic t_unmapped;
		wr(18'h0e102, 16'hffff);
		rd(18'h0e102, 16'h0000);
		rd(rcm_pkg::IDX_LOCK_MUTE_LO, 16'h0f00);
		$display("test unmapped done");
	endtask
	task automatic complete_run;
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	// Main sequence
	initial begin
		repeat (6) @(posedge clk);
		sys_rst <= 1'b0;
		t_reset();
		t_lock();
		t_ramp();
		t_rdis();
		t_variant();
		t_unmapped();
		complete_run();
	end
endmodule
`default_nettype wire
